// >>> verif/pir_cpu_model.sv
`timescale 1ns/100ps
module pir_cpu_model
(
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Processor interrupt lines.
   input wire pir_pkg::pir_lines_t lines_in,
   // Number of fast requests seen.
   output int fast_rises_out
);
   import pir_pkg::*;
   logic last_fast;
   // The core counts each new fast request, as its entry would.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         last_fast <= 1'b0;
         fast_rises_out <= 0;
      end
      else
      begin
         last_fast <= lines_in.fast;
         if (lines_in.fast && !last_fast) fast_rises_out <= fast_rises_out + 1;
      end
   end
endmodule : pir_cpu_model

// >>> verif/pir_router_sva.sv
`timescale 1ns/100ps
module pir_router_sva
   import pir_pkg::*;
#(
   parameter int NUM_REQ = 56
) (
   // Clock, enable and reset.
   input wire logic CORE_CLK_IN,
   input wire logic CLK_EN_IN,
   input wire logic RST_IN,
   // Register bus.
   input wire pir_pkg::pir_axi_req_t AXI_REQ_IN,
   input wire pir_pkg::pir_axi_rsp_t AXI_RSP_OUT,
   // Requests and lines.
   input wire logic [NUM_REQ-1:0] REQ_IN,
   input wire pir_pkg::pir_lines_t LINES_OUT,
   input wire logic IRQ_OUT
);
   pir_axi_req_t q;
   pir_axi_rsp_t s;
   // Short aliases for the bus structs.
   assign q = AXI_REQ_IN;
   assign s = AXI_RSP_OUT;
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   sequence s_rd_taken; q.arvalid && s.arready && CLK_EN_IN; endsequence
   sequence s_wr_taken; q.awvalid && s.awready && q.wvalid && s.wready && CLK_EN_IN; endsequence
   property p_rd_lat; s_rd_taken |=> s.rvalid; endproperty
   property p_rd_hold; s.rvalid && !(q.rready && CLK_EN_IN) |=> s.rvalid && $stable(s.rdata);
   endproperty
   property p_rd_drop; s.rvalid && q.rready && CLK_EN_IN |=> !s.rvalid; endproperty
   property p_ar_block; s.rvalid |-> !s.arready; endproperty
   property p_wr_lat; s_wr_taken ##1 CLK_EN_IN |=> s.bvalid; endproperty
   property p_bv_hold; s.bvalid && !(q.bready && CLK_EN_IN) |=> s.bvalid; endproperty
   property p_w_block; s.bvalid |-> !s.awready && !s.wready; endproperty
   property p_freeze; !CLK_EN_IN |=> $stable(LINES_OUT) && $stable(IRQ_OUT); endproperty
   property p_irq_cause; $rose(IRQ_OUT) |->
      $rose(LINES_OUT.fast) || $rose(LINES_OUT.standard) || $rose(s.bvalid); endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   a_rd_drop: assert property (p_rd_drop) else $error("read answer stuck");
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   a_bv_hold: assert property (p_bv_hold) else $error("write answer dropped");
   a_w_block: assert property (p_w_block) else $error("write taken while busy");
   a_freeze: assert property (p_freeze) else $error("state moved while gated");
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without event");
endmodule : pir_router_sva
bind pir_router pir_router_sva #(.NUM_REQ(NUM_REQ)) u_sva (.CORE_CLK_IN(CORE_CLK_IN),
   .CLK_EN_IN(CLK_EN_IN), .RST_IN(RST_IN), .AXI_REQ_IN(AXI_REQ_IN), .AXI_RSP_OUT(AXI_RSP_OUT),
   .REQ_IN(REQ_IN), .LINES_OUT(LINES_OUT), .IRQ_OUT(IRQ_OUT));

// >>> verif/testbench.sv
`timescale 1ns/100ps
`include "pir_defines.svh"
module testbench;
   import pir_pkg::*;
   typedef struct packed {logic [3:0] p; logic t; logic [3:0] tf; logic [3:0] ts; logic [1:0] e;}
      pir_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   pir_axi_req_t q = '0;
   pir_axi_rsp_t s;
   logic [55:0] req = '0;
   pir_lines_t lines;
   logic irq;
   logic [31:0] rd;
   logic [1:0] rs;
   int fast_rises;
   int num_errors = 0;
   int check_count = 0;
   // Priority, target, thresholds and the expected {standard, fast} lines.
   pir_row_t rows [7] = '{'{4'h0, 1'h0, 4'h0, 4'h0, 2'h0}, '{4'h1, 1'h0, 4'h0, 4'h0, 2'h1},
      '{4'h5, 1'h0, 4'h5, 4'h0, 2'h0}, '{4'h6, 1'h0, 4'h5, 4'h0, 2'h1},
      '{4'hF, 1'h1, 4'h0, 4'hE, 2'h2}, '{4'hF, 1'h1, 4'h0, 4'hF, 2'h0},
      '{4'h3, 1'h1, 4'h9, 4'h2, 2'h2}};
   // Free-running core clock.
   always #50 clk = ~clk;
   pir_router #(.NUM_REQ(56)) DUT (.CORE_CLK_IN(clk), .CLK_EN_IN(en), .RST_IN(rst),
      .AXI_REQ_IN(q), .AXI_RSP_OUT(s), .REQ_IN(req), .LINES_OUT(lines), .IRQ_OUT(irq));
   pir_cpu_model cpu (.clk_in(clk), .rst_in(rst), .lines_in(lines), .fast_rises_out(fast_rises));
   //////////////////////////////////////////////////
   task automatic test_done;
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Write one word; waits for the answer and keeps the response code.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      q.awaddr <= a;
      q.wdata <= d;
      q.wstrb <= 4'hF;
      q.awvalid <= 1'b1;
      q.wvalid <= 1'b1;
      q.bready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (q.awvalid && s.awready) q.awvalid <= 1'b0;
         if (q.wvalid && s.wready) q.wvalid <= 1'b0;
      end
      while (!s.bvalid && n < 50);
      rs = s.bresp;
      q.bready <= 1'b0;
      if (n >= 50) num_errors++;
   endtask : wr
   // Read one word into rd and its response code into rs.
   task automatic rdw(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge clk);
      q.araddr <= a;
      q.arvalid <= 1'b1;
      q.rready <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (q.arvalid && s.arready) q.arvalid <= 1'b0;
      end
      while (!s.rvalid && n < 50);
      rd = s.rdata;
      rs = s.rresp;
      q.rready <= 1'b0;
      if (n >= 50) num_errors++;
   endtask : rdw
   function automatic logic [31:0] cw(logic [3:0] p, logic t, logic pol, logic sw);
      return {15'h0, 1'h1, 5'h0, sw, pol, t, 4'h0, p};
   endfunction : cw
   // Hang guard.
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      test_done();
   end
   // Main sequence.
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdw(`PIR_OFS_THR_FAST);
      chk(rd, 32'h0);
      req[0] <= 1'b1;
      foreach (rows[k])
      begin
         wr(`PIR_OFS_THR_FAST, {28'h0, rows[k].tf});
         wr(`PIR_OFS_THR_STD, {28'h0, rows[k].ts});
         wr(`PIR_OFS_REQ_BASE, cw(rows[k].p, rows[k].t, 1'h0, 1'h0));
         chk({30'h0, rs}, {30'h0, `PIR_RESP_OKAY});
         repeat (2) @(posedge clk);
         chk({30'h0, lines}, {30'h0, rows[k].e});
         rdw(`PIR_OFS_RAW_LO);
         chk({31'h0, rd[0]}, 32'h1);
      end
      rdw(`PIR_OFS_STATUS);
      chk(rd, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wr(`PIR_OFS_MASK, 32'h1);
      wr(`PIR_OFS_THR_FAST, 32'h0);
      wr(`PIR_OFS_REQ_BASE, 32'h0);
      wr(`PIR_OFS_REQ_BASE + 12'h0DC, cw(4'h4, 1'h0, 1'h1, 1'h0));
      repeat (2) @(posedge clk);
      chk({30'h0, lines}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      chk(fast_rises, 32'h3);
      rdw(`PIR_OFS_RAW_HI);
      chk({31'h0, rd[23]}, 32'h1);
      rdw(`PIR_OFS_STATUS);
      chk(rd, 32'h1);
      chk({31'h0, irq}, 32'h0);
      req[55] <= 1'b1;
      wr(`PIR_OFS_REQ_BASE + 12'h01C, cw(4'h9, 1'h1, 1'h0, 1'h1));
      repeat (2) @(posedge clk);
      chk({30'h0, lines}, 32'h2);
      rdw(`PIR_OFS_PEND_LO);
      chk(rd, 32'h00000080);
      rdw(12'h020);
      chk({30'h0, rs}, {30'h0, `PIR_RESP_SLVERR});
      en <= 1'b0;
      req[55] <= 1'b0;
      repeat (3) @(posedge clk);
      chk({30'h0, lines}, 32'h2);
      en <= 1'b1;
      repeat (2) @(posedge clk);
      chk({30'h0, lines}, 32'h3);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk({30'h0, lines}, 32'h0);
      test_done();
   end
endmodule : testbench

// >>> verilog/pir_defines.svh
`ifndef PIR_DEFINES_SVH
`define PIR_DEFINES_SVH

// Number of request inputs and priority width.
`define PIR_NUM_REQ 56
`define PIR_PRIO_W 4

// Register byte offsets.
`define PIR_OFS_THR_FAST 12'h000
`define PIR_OFS_THR_STD 12'h004
`define PIR_OFS_STATUS 12'h008
`define PIR_OFS_MASK 12'h00C
`define PIR_OFS_RAW_LO 12'h010
`define PIR_OFS_RAW_HI 12'h014
`define PIR_OFS_PEND_LO 12'h018
`define PIR_OFS_PEND_HI 12'h01C
`define PIR_OFS_REQ_BASE 12'h100

// Per-request control word fields.
`define PIR_FLD_PRIO_LSB 0
`define PIR_FLD_TARGET 8
`define PIR_FLD_POLARITY 9
`define PIR_FLD_SWREQ 10
`define PIR_FLD_ENABLE 16

// Reset values.
`define PIR_RST_THR 4'h0
`define PIR_RST_MASK 2'h0

// Status bit positions.
`define PIR_ST_FAST 0
`define PIR_ST_STD 1

// AXI response codes.
`define PIR_RESP_OKAY 2'h0
`define PIR_RESP_SLVERR 2'h2

`endif

// >>> verilog/pir_pkg.sv
package pir_pkg;

   // Per-request configuration.
   typedef struct packed
   {
      logic enable;
      logic swreq;
      logic polarity;
      logic target;
      logic [3:0] prio;
   } pir_cfg_t;

   // Write and read bus signals from the master.
   typedef struct packed
   {
      logic [11:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [11:0] araddr;
      logic arvalid;
      logic rready;
   } pir_axi_req_t;

   // Answer signals to the master.
   typedef struct packed
   {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } pir_axi_rsp_t;

   // Target line pair.
   typedef struct packed
   {
      logic standard;
      logic fast;
   } pir_lines_t;

endpackage : pir_pkg

// >>> verilog/pir_router.sv
`timescale 1ns/100ps
`include "pir_defines.svh"

module pir_router #(
   parameter int NUM_REQ = `PIR_NUM_REQ
) (
   // Clock, enable and reset.
   input wire logic CORE_CLK_IN,
   input wire logic CLK_EN_IN,
   input wire logic RST_IN,
   // Register bus.
   input wire pir_pkg::pir_axi_req_t AXI_REQ_IN,
   output pir_pkg::pir_axi_rsp_t AXI_RSP_OUT,
   // Peripheral request levels.
   input wire logic [NUM_REQ-1:0] REQ_IN,
   // Processor lines and summary interrupt.
   output pir_pkg::pir_lines_t LINES_OUT,
   output logic IRQ_OUT
);
   import pir_pkg::*;

   localparam int PW = `PIR_PRIO_W;

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   typedef enum logic [1:0] {WR_IDLE, WR_RESP} pir_wr_st_t;

   typedef struct packed
   {
      pir_cfg_t [NUM_REQ-1:0] cfg;
      logic [PW-1:0] thr_fast;
      logic [PW-1:0] thr_std;
      logic [1:0] status;
      logic [1:0] mask;
      logic [NUM_REQ-1:0] raw;
      pir_lines_t lines;
      pir_wr_st_t wr_st;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic bad_wr;
      logic rvalid;
      logic [31:0] rdata;
      logic bad_rd;
   } pir_state_t;

   pir_state_t st;
   pir_state_t next_st;

   // Combinational helpers.
   logic [NUM_REQ-1:0] active;
   logic [NUM_REQ-1:0] hit_fast;
   logic [NUM_REQ-1:0] hit_std;
   logic [63:0] raw_w;
   logic [63:0] pend_fast_w;
   logic [63:0] pend_std_w;

   ////////////////////////////////////////////////////////////////////////////////
   // Request evaluation.

   // Each input is polarity-corrected, merged with its software request and then masked.
   always_comb
   begin
      for (int i = 0; i < NUM_REQ; i++)
      begin
         active[i] = st.cfg[i].enable &
                     ((REQ_IN[i] ^ st.cfg[i].polarity) | st.cfg[i].swreq);
         hit_fast[i] = active[i] && (st.cfg[i].target == 1'b0)
                       && (st.cfg[i].prio != '0)
                       && (st.cfg[i].prio > st.thr_fast);
         hit_std[i] = active[i] && (st.cfg[i].target == 1'b1)
                      && (st.cfg[i].prio != '0)
                      && (st.cfg[i].prio > st.thr_std);
      end
      raw_w = 64'h0;
      pend_fast_w = 64'h0;
      pend_std_w = 64'h0;
      raw_w[NUM_REQ-1:0] = st.raw;
      pend_fast_w[NUM_REQ-1:0] = hit_fast;
      pend_std_w[NUM_REQ-1:0] = hit_std;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // Register bus slave, status capture and line update.
   always_comb
   begin
      logic [11:0] ra;
      logic [11:0] idx;
      logic do_wr;
      logic do_rd;
      ra = 12'h0;
      idx = 12'h0;
      do_wr = 1'b0;
      do_rd = 1'b0;
      next_st = st;

      // Raw levels are recorded before any priority masking.
      next_st.raw = active;
      next_st.lines.fast = |hit_fast;
      next_st.lines.standard = |hit_std;

      // Write address and data are taken in either order.
      if (st.wr_st == WR_IDLE)
      begin
         if (AXI_REQ_IN.awvalid && !st.aw_got)
         begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = AXI_REQ_IN.awaddr;
         end
         if (AXI_REQ_IN.wvalid && !st.w_got)
         begin
            next_st.w_got = 1'b1;
            next_st.wdata = AXI_REQ_IN.wdata;
         end
         do_wr = st.aw_got && st.w_got;
      end
      else if (AXI_REQ_IN.bready)
      begin
         next_st.wr_st = WR_IDLE;
      end

      // Register write with full-word strobes assumed for control fields.
      if (do_wr)
      begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.wr_st = WR_RESP;
         next_st.bad_wr = 1'b0;
         case (st.awaddr)
            `PIR_OFS_THR_FAST: next_st.thr_fast = st.wdata[PW-1:0];
            `PIR_OFS_THR_STD: next_st.thr_std = st.wdata[PW-1:0];
            `PIR_OFS_MASK: next_st.mask = st.wdata[1:0];
            `PIR_OFS_STATUS,
            `PIR_OFS_RAW_LO,
            `PIR_OFS_RAW_HI,
            `PIR_OFS_PEND_LO,
            `PIR_OFS_PEND_HI: next_st.bad_wr = 1'b0;
            default:
            begin
               idx = (st.awaddr - `PIR_OFS_REQ_BASE) >> 2;
               if (st.awaddr >= `PIR_OFS_REQ_BASE && idx < 12'(NUM_REQ)
                   && st.awaddr[1:0] == 2'b00)
               begin
                  next_st.cfg[idx].prio = st.wdata[`PIR_FLD_PRIO_LSB +: PW];
                  next_st.cfg[idx].target = st.wdata[`PIR_FLD_TARGET];
                  next_st.cfg[idx].polarity = st.wdata[`PIR_FLD_POLARITY];
                  next_st.cfg[idx].swreq = st.wdata[`PIR_FLD_SWREQ];
                  next_st.cfg[idx].enable = st.wdata[`PIR_FLD_ENABLE];
               end
               else
               begin
                  next_st.bad_wr = 1'b1;
               end
            end
         endcase
      end

      // Read channel: address taken when no read answer is pending.
      do_rd = AXI_REQ_IN.arvalid && !st.rvalid;
      if (st.rvalid && AXI_REQ_IN.rready)
      begin
         next_st.rvalid = 1'b0;
      end
      if (do_rd)
      begin
         ra = AXI_REQ_IN.araddr;
         next_st.rvalid = 1'b1;
         next_st.bad_rd = 1'b0;
         next_st.rdata = 32'h0;
         case (ra)
            `PIR_OFS_THR_FAST: next_st.rdata[PW-1:0] = st.thr_fast;
            `PIR_OFS_THR_STD: next_st.rdata[PW-1:0] = st.thr_std;
            `PIR_OFS_STATUS: next_st.rdata[1:0] = st.status;
            `PIR_OFS_MASK: next_st.rdata[1:0] = st.mask;
            `PIR_OFS_RAW_LO: next_st.rdata = raw_w[31:0];
            `PIR_OFS_RAW_HI: next_st.rdata = raw_w[63:32];
            `PIR_OFS_PEND_LO: next_st.rdata = pend_fast_w[31:0] | pend_std_w[31:0];
            `PIR_OFS_PEND_HI: next_st.rdata = pend_fast_w[63:32] | pend_std_w[63:32];
            default:
            begin
               idx = (ra - `PIR_OFS_REQ_BASE) >> 2;
               if (ra >= `PIR_OFS_REQ_BASE && idx < 12'(NUM_REQ) && ra[1:0] == 2'b00)
               begin
                  next_st.rdata[`PIR_FLD_PRIO_LSB +: PW] = st.cfg[idx].prio;
                  next_st.rdata[`PIR_FLD_TARGET] = st.cfg[idx].target;
                  next_st.rdata[`PIR_FLD_POLARITY] = st.cfg[idx].polarity;
                  next_st.rdata[`PIR_FLD_SWREQ] = st.cfg[idx].swreq;
                  next_st.rdata[`PIR_FLD_ENABLE] = st.cfg[idx].enable;
               end
               else
               begin
                  next_st.bad_rd = 1'b1;
               end
            end
         endcase
      end

      // Status bits are sticky; a read clears them but a new event wins.
      if (do_rd && ra == `PIR_OFS_STATUS)
      begin
         next_st.status = 2'h0;
      end
      if (next_st.lines.fast && !st.lines.fast)
      begin
         next_st.status[`PIR_ST_FAST] = 1'b1;
      end
      if (next_st.lines.standard && !st.lines.standard)
      begin
         next_st.status[`PIR_ST_STD] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.

   // Everything runs on the router branch clock, frozen while the enable is low.
   always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         st <= '0;
         st.thr_fast <= `PIR_RST_THR;
         st.thr_std <= `PIR_RST_THR;
         st.mask <= `PIR_RST_MASK;
         st.wr_st <= WR_IDLE;
      end
      else if (CLK_EN_IN)
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Bus answers; ready strobes are combinational.
   always_comb
   begin
      AXI_RSP_OUT.awready = (st.wr_st == WR_IDLE) && !st.aw_got;
      AXI_RSP_OUT.wready = (st.wr_st == WR_IDLE) && !st.w_got;
      AXI_RSP_OUT.bvalid = (st.wr_st == WR_RESP);
      AXI_RSP_OUT.bresp = st.bad_wr ? `PIR_RESP_SLVERR : `PIR_RESP_OKAY;
      AXI_RSP_OUT.arready = !st.rvalid;
      AXI_RSP_OUT.rvalid = st.rvalid;
      AXI_RSP_OUT.rdata = st.rdata;
      AXI_RSP_OUT.rresp = st.bad_rd ? `PIR_RESP_SLVERR : `PIR_RESP_OKAY;
   end

   // Processor lines come from flip-flops; the summary interrupt is gated by the mask.
   assign LINES_OUT = st.lines;
   assign IRQ_OUT = |(st.status & st.mask);

endmodule : pir_router
